//--- hdl/steer_pkg.sv
package steer_pkg;
  localparam int unsigned REG_W = 8;
  // byte address of the steering register on the bus
  localparam logic [7:0] STEER_CTRL_ADDR = 8'h00;
  localparam logic [7:0] POL_CTRL_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'hFC;
  // field positions in output_steering_control
  localparam int unsigned STEER_A_BIT = 0;
  localparam int unsigned STEER_B_BIT = 1;
  localparam int unsigned STEER_C_BIT = 2;
  localparam int unsigned STEER_D_BIT = 3;
  localparam int unsigned SDAT_A_BIT = 4;
  localparam int unsigned SDAT_B_BIT = 5;
  localparam int unsigned SDAT_C_BIT = 6;
  localparam int unsigned SDAT_D_BIT = 7;
  localparam logic [7:0] STEER_RESET = 8'h00;
  localparam logic [3:0] POL_RESET = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- hdl/steer_cfg_if.sv
`timescale 1ns/1ns
`default_nettype none
interface steer_cfg_if;
  logic [3:0] steer_en;
  logic [3:0] static_lvl;
  logic [3:0] polarity;
  logic [3:0] drive;
  modport ctrl (output steer_en, output static_lvl, output polarity, input drive);
  modport mux (input steer_en, input static_lvl, input polarity, output drive);
endinterface
`default_nettype wire

//--- hdl/steer_mux.sv
`timescale 1ns/1ns
`default_nettype none
module steer_mux
  import steer_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [3:0] wave_in,
  steer_cfg_if.mux cfg
);
  typedef struct packed {
    logic [3:0] drive;
  } mux_state_s;
  mux_state_s st_q, st_d;
  logic [3:0] sel;

  // per output: waveform xor polarity when steered, else static level
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      sel[i] = cfg.steer_en[i] ? (wave_in[i] ^ cfg.polarity[i]) : cfg.static_lvl[i];
    end
    st_d.drive = sel;
  end

  // registered so a source change lands cleanly on one edge
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign cfg.drive = st_q.drive;
endmodule
`default_nettype wire

//--- hdl/cog_output_steering.sv
`timescale 1ns/1ns
`default_nettype none
module cog_output_steering
  import steer_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [3:0] wave_in,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic drive_out_a,
  output logic drive_out_b,
  output logic drive_out_c,
  output logic drive_out_d
);
  typedef struct packed {
    logic [7:0] steer_ctrl;
    logic [3:0] pol;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } regs_s;
  regs_s st_q, st_d;
  steer_cfg_if cfg ();

  function automatic logic [7:0] word_addr(input logic [7:0] a);
    return a & ADDR_MASK;
  endfunction

  logic do_write;
  logic [7:0] wa;

  assign s_axi_awready = !st_q.aw_got && !st_q.bvalid;
  assign s_axi_wready = !st_q.w_got && !st_q.bvalid;
  assign s_axi_arready = !st_q.rvalid;

  always_comb begin
    st_d = st_q;
    if (s_axi_awvalid && s_axi_awready) begin
      st_d.aw_got = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_d.w_got = 1'b1;
      st_d.w_data = s_axi_wdata[7:0];
      st_d.w_lane0 = s_axi_wstrb[0];
    end
    do_write = st_q.aw_got && st_q.w_got;
    wa = word_addr(st_q.aw_addr);
    if (do_write) begin
      st_d.aw_got = 1'b0;
      st_d.w_got = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = RESP_OKAY;
      if (wa == STEER_CTRL_ADDR) begin
        // all eight bits in one byte lane
        if (st_q.w_lane0) begin
          st_d.steer_ctrl = st_q.w_data;
        end
      end else if (wa == POL_CTRL_ADDR) begin
        if (st_q.w_lane0) begin
          st_d.pol = st_q.w_data[3:0];
        end
      end else if (wa != STATUS_ADDR) begin
        st_d.bresp = RESP_SLVERR;
      end
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = RESP_OKAY;
      st_d.rdata = 32'h0000_0000;
      unique case (word_addr(s_axi_araddr))
        STEER_CTRL_ADDR: st_d.rdata[7:0] = st_q.steer_ctrl;
        POL_CTRL_ADDR: st_d.rdata[3:0] = st_q.pol;
        STATUS_ADDR: st_d.rdata[3:0] = cfg.drive;
        default: st_d.rresp = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q <= '0;
      st_q.steer_ctrl <= STEER_RESET;
      st_q.pol <= POL_RESET;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // steer bit 0 chooses A's source; B..D at bits 1..3
  assign cfg.steer_en = {st_q.steer_ctrl[STEER_D_BIT], st_q.steer_ctrl[STEER_C_BIT],
                         st_q.steer_ctrl[STEER_B_BIT], st_q.steer_ctrl[STEER_A_BIT]};
  // static levels feed the mux when steering is off
  assign cfg.static_lvl = {st_q.steer_ctrl[SDAT_D_BIT], st_q.steer_ctrl[SDAT_C_BIT],
                           st_q.steer_ctrl[SDAT_B_BIT], st_q.steer_ctrl[SDAT_A_BIT]};
  assign cfg.polarity = st_q.pol;

  steer_mux u_mux (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .wave_in(wave_in),
    .cfg(cfg.mux)
  );

  assign drive_out_a = cfg.drive[0];
  assign drive_out_b = cfg.drive[1];
  assign drive_out_c = cfg.drive[2];
  assign drive_out_d = cfg.drive[3];

  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;
endmodule
`default_nettype wire

//--- tb/steer_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module steer_asserts (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic drive_out_d,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready && clk_en;
  endsequence
  AST_WR_ANS: assert property (wr_take ##1 clk_en |=> s_axi_bvalid) else $error("b late");
  AST_RD_ANS: assert property (rd_take |=> s_axi_rvalid) else $error("r late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b drop");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("r drop");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready && clk_en |=> !s_axi_bvalid) else $error("b stuck");
  AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready && clk_en |=> !s_axi_rvalid) else $error("r stuck");
  AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("w ready");
  AST_R_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar ready");
  AST_FREEZE: assert property (!clk_en |=> $stable(drive_out_d)) else $error("pin moved");
endmodule
bind cog_output_steering steer_asserts chk_u (.*);
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import steer_pkg::*;
  logic core_clk = 0, sys_rst = 1, clk_en = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic drive_out_a, drive_out_b, drive_out_c, drive_out_d;
  logic [3:0] wave_in = 4'h0, s_axi_wstrb = 4'hf, s;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, a;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, d, e;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int mismatches = 0, comparisons = 0, seed = 4, t, ctrl = 0, pol = 0;
  cog_output_steering dut_u (.*);
  always #10 core_clk = ~core_clk;
  function automatic logic [3:0] pins(input logic [3:0] w);
    for (int i = 0; i < 4; i++) pins[i] = ctrl[i] ? w[i] ^ pol[i] : ctrl[4 + i];
  endfunction
  task automatic chk(input logic [31:0] g, x);
    comparisons++;
    if (g !== x) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic conclude;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr;
    @(posedge core_clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    t = 0;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      t++;
    end while (s_axi_bvalid !== 1 && t < 50);
    if (s_axi_bvalid !== 1) begin mismatches++; conclude; end
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd;
    @(posedge core_clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    t = 0;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      t++;
    end while (s_axi_rvalid !== 1 && t < 50);
    if (s_axi_rvalid !== 1) begin mismatches++; conclude; end
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 0;
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 0;
    a = STEER_CTRL_ADDR;
    rd;
    chk(d, STEER_RESET);
    for (int k = 0; k < 80; k++) begin
      a = 8'(($random(seed) & 3) << 2);
      d = $random(seed);
      s = $random(seed);
      wr;
      chk(r, a > 8 ? RESP_SLVERR : RESP_OKAY);
      // a dropped lane-0 strobe must leave the model untouched
      if (s[0] && a == 0) ctrl = d[7:0];
      if (s[0] && a == 4) pol = d[3:0];
      e = a == 0 ? ctrl : a == 4 ? pol : pins(wave_in);
      rd;
      chk(r, a > 8 ? RESP_SLVERR : RESP_OKAY);
      if (a < 12) chk(d, e);
      if (k % 4 == 0) begin
        e = pins(wave_in);
        @(posedge core_clk) {clk_en, wave_in} <= {1'b0, ~wave_in};
        repeat (2) @(negedge core_clk);
        chk({drive_out_d, drive_out_c, drive_out_b, drive_out_a}, e);
        @(posedge core_clk) clk_en <= 1;
      end
      @(posedge core_clk) wave_in <= $random(seed);
      @(posedge core_clk);
      @(negedge core_clk) chk({drive_out_d, drive_out_c, drive_out_b, drive_out_a}, pins(wave_in));
    end
    conclude;
  end
endmodule
`default_nettype wire
